// [inc/scd_pkg.sv]
// Shared constants and carrier types for the strap configuration decoder.
package scd_pkg;

  // Converter result width and decoded strap code width.
  localparam int ADC_WIDTH = 8;
  localparam int CODE_WIDTH = 3;
  localparam int CHAN_WIDTH = 3;
  localparam int NUM_THRESH = 7;

  // Converter multiplexer channels; codes above the last one are refused.
  localparam logic [2:0] CH_STRAP_FIRST = 3'h0;
  localparam logic [2:0] CH_STRAP_SECOND = 3'h1;
  localparam logic [2:0] CH_PIN_FOUR = 3'h2;
  localparam logic [2:0] CH_PIN_FIVE = 3'h3;
  localparam logic [2:0] CH_INT_VOLTAGE = 3'h4;
  localparam logic [2:0] CH_INT_CURRENT = 3'h5;
  localparam logic [2:0] CH_LAST = 3'h5;

  // Upper code of each strap value 0..6, ratio times full scale 255,
  // rounded down; anything above the last one decodes to 7.
  localparam logic [NUM_THRESH-1:0][7:0] STRAP_THRESH = {
    8'hE7, 8'hB4, 8'h5D, 8'h3C, 8'h24, 8'h12, 8'h05};

  // Seven-bit slave addresses on the controller management bus.
  localparam logic [6:0] ADDR_BASE = 7'h20;
  localparam logic [6:0] ADDR_PORT_B = 7'h04;
  localparam logic [1:0] ADDR_IDX_MAX = 2'h2;

  // Second strap value that selects the safe option.
  localparam logic [2:0] SAFE_CODE = 3'h7;

  // Sample-and-hold settling time, rounded up to whole clocks.
  localparam int CLK_PERIOD_NS = 4;
  localparam int SAMPLE_TIME_NS = 40;
  localparam int SAMPLE_CYCLES =
    (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Conversion request from firmware.
  typedef struct packed {
    logic [CHAN_WIDTH-1:0] channel;
  } scd_req_t;

  // Conversion result returned to firmware.
  typedef struct packed {
    logic [CHAN_WIDTH-1:0] channel;
    logic [ADC_WIDTH-1:0] data;
  } scd_result_t;

  // The latched pair of decoded strap values.
  typedef struct packed {
    logic [CODE_WIDTH-1:0] first;
    logic [CODE_WIDTH-1:0] second;
  } scd_straps_t;

endpackage

// [logic/scd_level_decode.sv]
// Turns an 8-bit strap conversion into its three-bit strap value.
module scd_level_decode (
  input wire logic [7:0] level,
  output logic [2:0] code
);

  // One flag per boundary, set when the level lies above it.
  logic [scd_pkg::NUM_THRESH-1:0] above;

  // Each boundary is compared in its own slice.
  genvar gi;
  generate
    for (gi = 0; gi < scd_pkg::NUM_THRESH; gi++) begin : g_cmp
      assign above[gi] = level > scd_pkg::STRAP_THRESH[gi];
    end
  endgenerate

  // The flags form a thermometer, so their count is the value.
  always_comb begin
    code = 3'h0;
    for (int i = 0; i < scd_pkg::NUM_THRESH; i++) begin
      code = code + {2'h0, above[i]};
    end
  end

endmodule

// [logic/strap_config_decoder.sv]
// Power-up strap decoder with its successive-approximation converter.
//
// Contract
// - Convert both straps at power-up, then use.
// - Divider ratio bands decode to values 0..7.
// - Strap pair selects address, sink, default config.
// - Straps govern dead-battery response without main supply.
// - Converter is 8-bit successive approximation.
// - Input multiplexer; every result readable by firmware.
// - Only pins four and five are analog.
// - After boot, each port gets distinct address.
// - Overvoltage clear re-enables both gates unless safe.
module strap_config_decoder (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic compAbove,
  output logic [7:0] dacCode,
  output logic [2:0] muxSel,
  output logic sampleHold,
  input wire logic reqValid,
  input wire scd_pkg::scd_req_t req,
  output logic reqReady,
  output logic reqRefused,
  output logic resultValid,
  output scd_pkg::scd_result_t result,
  output logic strapValid,
  output scd_pkg::scd_straps_t straps,
  output logic [2:0] defaultConfig,
  output logic strapSafeOption,
  input wire logic bootDone,
  output logic [6:0] portAAddr,
  output logic [6:0] portBAddr,
  output logic portBAddrValid,
  input wire logic mainSupplyGood,
  input wire logic portABusPower,
  input wire logic portBBusPower,
  input wire logic overVoltage,
  output logic deadBattery,
  output logic sinkGateEnA,
  output logic sinkGateEnB
);

  // Converter sequencer states.
  typedef enum logic [1:0] {
    SCD_IDLE = 2'b00,
    SCD_SAMPLE = 2'b01,
    SCD_CONVERT = 2'b10,
    SCD_FINISH = 2'b11
  } scd_state_t;

  // Power-up progress: which strap is pending, or done.
  typedef enum logic [1:0] {
    SCD_BOOT_FIRST = 2'b00,
    SCD_BOOT_SECOND = 2'b01,
    SCD_BOOT_DONE = 2'b10
  } scd_boot_t;

  scd_state_t state; // Sequencer state.
  scd_boot_t boot; // Power-up strap progress.
  logic [5:0] waitCount; // Sample settling counter.
  logic [2:0] bitIdx; // Bit currently being trialled.
  logic [7:0] sarValue; // Result of the last finished conversion.
  logic [2:0] decoded; // Strap value of the finished conversion.

  // Request acceptance, refusal and start decode.
  logic fwAccept; // Firmware request taken this cycle.
  logic chanLegal; // Requested channel exists on the multiplexer.
  logic bootStart; // A power-up strap conversion begins.
  logic [2:0] bootChan; // Channel of the pending strap.
  logic [7:0] trialBit; // One-hot weight of the trial bit.
  logic [7:0] keptValue; // Value after the comparator decision.
  logic [1:0] addrIdx; // Address index chosen by the first strap.
  logic gatesAllowed; // Dead-battery sink paths may be on.

  assign reqReady = (state == SCD_IDLE) && (boot == SCD_BOOT_DONE);
  assign fwAccept = reqValid && reqReady;
  // Channel codes above CH_LAST have no multiplexer channel.
  assign chanLegal = req.channel <= scd_pkg::CH_LAST;
  assign bootStart = (state == SCD_IDLE) && (boot != SCD_BOOT_DONE);
  assign bootChan = (boot == SCD_BOOT_FIRST) ? scd_pkg::CH_STRAP_FIRST
                                             : scd_pkg::CH_STRAP_SECOND;
  assign trialBit = 8'h01 << bitIdx;
  // The comparator says the input is at or above the trial level.
  assign keptValue = compAbove ? dacCode : (dacCode & ~trialBit);
  assign addrIdx = (straps.first[1:0] > scd_pkg::ADDR_IDX_MAX)
                   ? scd_pkg::ADDR_IDX_MAX : straps.first[1:0];
  // The safe option is read straight from the latched pair, so the gates
  // never open for the one cycle before the safe flag register catches up.
  assign gatesAllowed = strapValid &&
                        (straps.second != scd_pkg::SAFE_CODE) &&
                        !overVoltage;

  // Boundary comparison of the conversion just finished.
  scd_level_decode u_decode (
    .level(sarValue),
    .code(decoded)
  );

  // Sequencer: select a channel, settle, then resolve one bit a clock.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= SCD_IDLE;
      muxSel <= 3'h0;
      sampleHold <= 1'b0;
      waitCount <= 6'h00;
      bitIdx <= 3'h7;
      dacCode <= 8'h00;
      sarValue <= 8'h00;
    end else begin
      case (state)
        SCD_IDLE: begin
          // Power-up straps go first; firmware waits until they are done.
          if (bootStart) begin
            muxSel <= bootChan;
            sampleHold <= 1'b1;
            waitCount <= 6'h00;
            state <= SCD_SAMPLE;
          end else if (fwAccept && chanLegal) begin
            muxSel <= req.channel;
            sampleHold <= 1'b1;
            waitCount <= 6'h00;
            state <= SCD_SAMPLE;
          end
        end
        SCD_SAMPLE: begin
          // Hold the input until the settling time has run out.
          if (waitCount == 6'(scd_pkg::SAMPLE_CYCLES - 1)) begin
            sampleHold <= 1'b0;
            bitIdx <= 3'h7;
            dacCode <= 8'h80;
            state <= SCD_CONVERT;
          end else begin
            waitCount <= waitCount + 6'h01;
          end
        end
        SCD_CONVERT: begin
          // Keep or drop the trial bit, then try the next lower one.
          if (bitIdx == 3'h0) begin
            sarValue <= keptValue;
            state <= SCD_FINISH;
          end else begin
            dacCode <= keptValue | (trialBit >> 1);
            bitIdx <= bitIdx - 3'h1;
          end
        end
        SCD_FINISH: begin
          state <= SCD_IDLE;
        end
        default: begin
          state <= SCD_IDLE;
        end
      endcase
    end
  end

  // Results go to firmware; the two power-up straps are latched once.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      boot <= SCD_BOOT_FIRST;
      resultValid <= 1'b0;
      result <= '0;
      reqRefused <= 1'b0;
      straps <= '0;
      strapValid <= 1'b0;
    end else begin
      resultValid <= 1'b0;
      reqRefused <= fwAccept && !chanLegal;
      if (state == SCD_FINISH) begin
        resultValid <= 1'b1;
        result.channel <= muxSel;
        result.data <= sarValue;
        if (boot == SCD_BOOT_FIRST) begin
          straps.first <= decoded;
          boot <= SCD_BOOT_SECOND;
        end else if (boot == SCD_BOOT_SECOND) begin
          straps.second <= decoded;
          strapValid <= 1'b1;
          boot <= SCD_BOOT_DONE;
        end
      end
    end
  end

  // Start-up options drawn from the latched strap pair.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      defaultConfig <= 3'h0;
      strapSafeOption <= 1'b0;
      portAAddr <= 7'h00;
      portBAddr <= 7'h00;
      portBAddrValid <= 1'b0;
    end else begin
      defaultConfig <= straps.second;
      strapSafeOption <= strapValid &&
                         (straps.second == scd_pkg::SAFE_CODE);
      portAAddr <= scd_pkg::ADDR_BASE | {5'h00, addrIdx};
      portBAddr <= scd_pkg::ADDR_BASE | scd_pkg::ADDR_PORT_B |
                   {5'h00, addrIdx};
      // Port B answers only once boot is complete.
      portBAddrValid <= strapValid && bootDone;
    end
  end

  // Dead-battery sink paths: off during overvoltage, back on after it
  // clears, kept off entirely when the safe option is strapped.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      deadBattery <= 1'b0;
      sinkGateEnA <= 1'b0;
      sinkGateEnB <= 1'b0;
    end else begin
      deadBattery <= !mainSupplyGood &&
                     (portABusPower || portBBusPower);
      sinkGateEnA <= deadBattery && gatesAllowed;
      sinkGateEnB <= deadBattery && gatesAllowed;
    end
  end

endmodule

// [verif/scd_divider_model.sv]
// Model of the strap dividers and analog comparator outside the core.
module scd_divider_model (
  input wire logic [7:0] levels [6],
  input wire logic [2:0] muxSel,
  input wire logic [7:0] dacCode,
  output logic compAbove
);
  timeunit 1ns;
  timeprecision 1ps;
  // The comparator reports whether the selected level reaches the trial.
  // Channels beyond the last input read low, as an open mux would.
  assign compAbove = (muxSel < 3'h6) &&
                     (levels[muxSel] >= dacCode);
endmodule

// [verif/scd_props.sv]
// Concurrent checks on the strap configuration decoder's ports.
module scd_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] dacCode,
  input wire logic sampleHold,
  input wire logic reqValid,
  input wire scd_pkg::scd_req_t req,
  input wire logic reqReady,
  input wire logic reqRefused,
  input wire logic resultValid,
  input wire logic strapValid,
  input wire scd_pkg::scd_straps_t straps,
  input wire logic [2:0] defaultConfig,
  input wire logic strapSafeOption,
  input wire logic [6:0] portAAddr,
  input wire logic [6:0] portBAddr,
  input wire logic portBAddrValid,
  input wire logic overVoltage,
  input wire logic sinkGateEnA,
  input wire logic sinkGateEnB
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // Checks on conversions, straps, addresses and sink gates.
  a_bad_refused: assert property (reqValid && reqReady
    && req.channel > 3'h5 |=> reqRefused) else $error("no refusal");
  a_result_time: assert property (reqValid && reqReady
    && req.channel < 3'h6 |-> ##20 resultValid) else $error("late result");
  a_sar_start: assert property ($fell(sampleHold)
    |-> dacCode == 8'h80) else $error("bad first trial");
  a_early_ready: assert property (!strapValid
    |-> !reqReady) else $error("ready before straps");
  a_straps_held: assert property (strapValid
    |=> strapValid && $stable(straps)) else $error("straps changed");
  a_default_cfg: assert property (strapValid && $past(strapValid)
    |-> defaultConfig == straps.second) else $error("bad default");
  a_safe_flag: assert property (strapValid && $past(strapValid)
    |-> strapSafeOption == (straps.second == 3'h7)) else $error("bad safe");
  a_addr_pair: assert property (portBAddrValid
    |-> portBAddr == portAAddr + 7'h04) else $error("bad address pair");
  a_ov_gates: assert property (overVoltage
    |=> !sinkGateEnA && !sinkGateEnB) else $error("gate on in overvoltage");
  a_safe_gates: assert property (strapSafeOption
    && $past(strapSafeOption) |-> !sinkGateEnA) else $error("gate in safe");
  a_safe_both: assert property (strapValid
    && straps.second == 3'h7 |=> !sinkGateEnA && !sinkGateEnB)
    else $error("gate on with safe straps");
endmodule

bind strap_config_decoder scd_props i_props (.mclk, .reset_n, .dacCode,
  .sampleHold, .reqValid, .req, .reqReady, .reqRefused, .resultValid,
  .strapValid, .straps, .defaultConfig, .strapSafeOption, .portAAddr,
  .portBAddr, .portBAddrValid, .overVoltage, .sinkGateEnA, .sinkGateEnB);

// [verif/tb_strap_config_decoder.sv]
// Self-checking bench for the strap configuration decoder.
module tb_strap_config_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, compAbove, reqValid, bootDone, sampleHold, reqReady;
  logic mainSupplyGood, portABusPower, portBBusPower, overVoltage;
  logic reqRefused, resultValid, strapValid, strapSafeOption, portBAddrValid;
  logic deadBattery, sinkGateEnA, sinkGateEnB;
  logic [7:0] dacCode;
  logic [2:0] muxSel, defaultConfig;
  logic [6:0] portAAddr, portBAddr;
  scd_pkg::scd_req_t req;
  scd_pkg::scd_result_t result;
  scd_pkg::scd_straps_t straps;
  logic [7:0] lv [6]; // Analog level on each converter channel.
  logic [7:0] up [8] = '{8'h05, 8'h12, 8'h24, 8'h3C, 8'h5D, 8'hB4, 8'hE7,
    8'hFF}; // Top level of each strap band.
  int failures = 0;
  int checkCount = 0;

  strap_config_decoder i_dut (.mclk, .reset_n, .compAbove, .dacCode,
    .muxSel, .sampleHold, .reqValid, .req, .reqReady, .reqRefused,
    .resultValid, .result, .strapValid, .straps, .defaultConfig,
    .strapSafeOption, .bootDone, .portAAddr, .portBAddr, .portBAddrValid,
    .mainSupplyGood, .portABusPower, .portBBusPower, .overVoltage,
    .deadBattery, .sinkGateEnA, .sinkGateEnB);
  scd_divider_model i_far (.levels(lv), .muxSel, .dacCode, .compAbove);

  // Free-running core clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Compares one value and counts any mismatch.
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (failures == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Strap value is the number of band tops the level exceeds.
  function automatic logic [2:0] expCode(input logic [7:0] v);
    int n = 0;
    for (int k = 0; k < 7; k++) if (v > scd_pkg::STRAP_THRESH[k]) n++;
    return n[2:0];
  endfunction

  // Steps n clock edges, staying just after the edge.
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Boots with two strap levels, then checks straps, addresses, gates.
  task automatic t_boot(input logic [7:0] a, input logic [7:0] b);
    logic [2:0] ea, eb;
    logic [1:0] ix;
    logic gate;
    int n;
    ea = expCode(a);
    eb = expCode(b);
    ix = (ea[1:0] > 2'h2) ? 2'h2 : ea[1:0];
    mainSupplyGood = (ea == 3'h3);
    portABusPower = a[0];
    portBBusPower = !a[0];
    gate = !mainSupplyGood && eb != 3'h7;
    lv[0] = a;
    lv[1] = b;
    reset_n = 1'b0;
    bootDone = 1'b0;
    step(2);
    reset_n = 1'b1;
    n = 0;
    while (strapValid !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    step(2);
    check(straps, {ea, eb});
    check(defaultConfig, eb);
    check(strapSafeOption, eb == 3'h7);
    check(deadBattery, !mainSupplyGood);
    check(sinkGateEnA, gate);
    check(portBAddrValid, 1'b0);
    bootDone = 1'b1;
    overVoltage = 1'b1;
    step(2);
    check(portAAddr, 7'h20 + 7'(ix));
    check(portBAddr, 7'h24 + 7'(ix));
    check(portBAddrValid, 1'b1);
    check(sinkGateEnB, 1'b0);
    overVoltage = 1'b0;
    step(2);
    check(sinkGateEnB, gate);
  endtask

  // Firmware conversion on one channel, refused above the last one.
  task automatic t_conv(input logic [2:0] ch);
    int n = 1;
    check(reqReady, 1'b1);
    req.channel = ch;
    reqValid = 1'b1;
    step(1);
    reqValid = 1'b0;
    if (ch > 3'h5) begin
      check(reqRefused, 1'b1);
      check(sampleHold, 1'b0);
    end else begin
      check(muxSel, ch);
      check(sampleHold, 1'b1);
      while (resultValid !== 1'b1 && n < 40) begin
        step(1);
        n++;
      end
      check(n, 20);
      check(result, {ch, lv[ch]});
    end
  endtask

  // Main sequence: every strap value on both inputs, then all channels.
  initial begin
    {reset_n, reqValid, bootDone, overVoltage} = 4'h0;
    {mainSupplyGood, portABusPower, portBBusPower} = 3'h1;
    req = '0;
    for (int k = 0; k < 6; k++) lv[k] = 8'h2B * k;
    for (int i = 0; i < 8; i++) begin
      t_boot(up[i], (i == 7) ? 8'h00 : up[6 - i] + 8'h01);
    end
    for (int c = 0; c < 8; c++) t_conv(c[2:0]);
    report_and_stop;
  end

  // Cuts a hang short well beyond the expected run.
  initial begin
    #20us;
    failures++;
    report_and_stop;
  end
endmodule
